// [rtl/low_voltage_detector.sv]
/*
 * Control and flag logic of the supply low-voltage detector: control
 * register, reference start-up timing, detect flag, wake and
 * interrupt requests.
 * Assumes the analog comparator, divider and reference sit outside;
 * their levels are asynchronous. Sleep and the register port are on
 * core_clk_i.
 */
`timescale 1ns/10ps
`include "lvd_defines.svh"

// Functional notes
// - Control bits 7 and 6 read zero and ignore writes.
// - Control bit 5 is a read-only reference-stable flag, zero at reset.
// - Control bit 4 powers the detector up when one, down when zero.
// - Control bits 3..0 select the trip point, reset value 0101.
// - Select 1111 senses the external pin instead of the divider.
// - 1110 is highest tap, 0010 lowest; 0001 and 0000 are reserved.
// - Interrupt enable must not be set while the stable flag is zero.
// - Detect flag may be spurious at start-up; software clears it.
// - Reference start-up delay is fixed time, not clock-dependent.
// - No trip sets the detect flag until the reference is stable.
// - Reference shared with brown-out; delay only if both were off.
// - Detector keeps running in sleep; a trip sets flag and wakes (the code wakes only while interrupt enable is set).
// - Wake with global interrupts on continues at the vector.
// - Any reset returns the control register to its reset value.
// - Flag sets when sensed voltage falls below the set point.
// - Flag set with its enable on branches to the interrupt vector.
module low_voltage_detector #(
   parameter int REF_STARTUP_CYC = `LVD_REF_STARTUP_CYC,
   parameter int TIMER_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [`LVD_ADDR_W-1:0] addr_i,
   input wire logic [`LVD_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [`LVD_DATA_W-1:0] rdata_o,
   input wire logic sleep_i,
   input wire logic comparator_low_i,
   input wire logic reference_ok_i,
   input wire logic brownout_ref_on_i,
   output logic detector_power_enable_o,
   output logic divider_enable_o,
   output logic [`LVD_SEL_W-1:0] trip_point_select_o,
   output logic external_sense_input_o,
   output logic reference_enable_o,
   output logic wake_o,
   output logic irq_o
);

   // ==================================================================
   // State
   lvd_pkg::lvd_state_t q;
   lvd_pkg::lvd_state_t d;

   logic cmp_low_s;
   logic ref_ok_s;
   logic bor_on_s;
   logic timer_done;
   logic ctrl_wr;
   logic irq_wr;
   logic trip;
   logic unsafe;

   // ==================================================================
   // Field decoding used in several places
   function automatic logic sel_reserved(
      input logic [`LVD_SEL_W-1:0] sel
   );
      sel_reserved = (sel < `LVD_SEL_MIN);
   endfunction

   function automatic logic sel_external(
      input logic [`LVD_SEL_W-1:0] sel
   );
      sel_external = (sel == `LVD_SEL_EXTERNAL);
   endfunction

   // ==================================================================
   // Crossing of analog levels into the clock domain
   lvd_sync #(
      .WIDTH(3)
   ) u_sync (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .async_i({comparator_low_i, reference_ok_i, brownout_ref_on_i}),
      .sync_o({cmp_low_s, ref_ok_s, bor_on_s})
   );

   // ==================================================================
   // Reference start-up timing, in cycles derived from a fixed time
   lvd_ref_timer #(
      .COUNT(REF_STARTUP_CYC),
      .CNT_W(TIMER_W)
   ) u_timer (
      .core_clk_i(core_clk_i),
      .rstn_i(rstn_i),
      .ref_on_i(q.ref_en),
      .done_o(timer_done)
   );

   // ==================================================================
   // Decode
   assign ctrl_wr = wr_i && (addr_i == `LVD_CTRL_ADDR);
   assign irq_wr = wr_i && (addr_i == `LVD_IRQ_ADDR);

   // Trip counts only once powered and the reference has settled
   assign trip = q.en && q.stable && cmp_low_s;

   // Interrupt enabled while results are not yet trustworthy
   assign unsafe = q.ie && !q.stable;

   // ==================================================================
   // Next state
   always_comb begin
      d = q;

      // Control register; bits 7..5 are not writable
      if (ctrl_wr) begin
         d.en = wdata_i[`LVD_CTRL_EN_BIT];
         d.sel = wdata_i[`LVD_CTRL_SEL_MSB:`LVD_CTRL_SEL_LSB];
      end

      // Interrupt control register
      if (irq_wr) begin
         d.ie = wdata_i[`LVD_IRQ_IE_BIT];
         d.global_irq_enable = wdata_i[`LVD_IRQ_GIE_BIT];
         d.flag = wdata_i[`LVD_IRQ_FLAG_BIT];
      end

      // Hardware set wins over a software clear in the same cycle
      if (trip) begin
         d.flag = 1'b1;
      end

      // Reference is shared: kept on by either user
      d.ref_en = q.en || bor_on_s;

      // Stable once powered, timer expired and the reference reports good
      d.stable = q.en && timer_done && ref_ok_s;

      // Analog steering
      d.pwr = q.en;
      d.ext = q.en && sel_external(q.sel);
      d.div_en = q.en && !sel_external(q.sel);
      if (sel_reserved(q.sel)) begin
         d.tap = `LVD_SEL_MIN;
      end else begin
         d.tap = q.sel;
      end

      // Wake from sleep on an enabled flag; vector when globally on
      d.wake = sleep_i && q.flag && q.ie;
      d.irq = q.flag && q.ie && q.global_irq_enable;

      // Read data stands only in the cycle after the strobe
      d.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            `LVD_CTRL_ADDR: begin
               d.rdata[`LVD_CTRL_STABLE_BIT] = q.stable;
               d.rdata[`LVD_CTRL_EN_BIT] = q.en;
               d.rdata[`LVD_CTRL_SEL_MSB:`LVD_CTRL_SEL_LSB] = q.sel;
            end
            `LVD_IRQ_ADDR: begin
               d.rdata[`LVD_IRQ_FLAG_BIT] = q.flag;
               d.rdata[`LVD_IRQ_IE_BIT] = q.ie;
               d.rdata[`LVD_IRQ_GIE_BIT] = q.global_irq_enable;
            end
            `LVD_STAT_ADDR: begin
               d.rdata[`LVD_STAT_STABLE_BIT] = q.stable;
               d.rdata[`LVD_STAT_REF_ON_BIT] = q.ref_en;
               d.rdata[`LVD_STAT_UNSAFE_BIT] = unsafe;
               d.rdata[`LVD_STAT_RSVD_BIT] = sel_reserved(q.sel);
               d.rdata[`LVD_STAT_EXT_BIT] = sel_external(q.sel);
               d.rdata[`LVD_STAT_SLEEP_BIT] = sleep_i;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
   end

   // ==================================================================
   // Registers
   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         q <= '0;
         q.sel <= `LVD_SEL_RESET;
         q.tap <= `LVD_SEL_RESET;
      end else begin
         q <= d;
      end
   end

   // ==================================================================
   // Outputs
   assign rdata_o = q.rdata;
   assign detector_power_enable_o = q.pwr;
   assign divider_enable_o = q.div_en;
   assign trip_point_select_o = q.tap;
   assign external_sense_input_o = q.ext;
   assign reference_enable_o = q.ref_en;
   assign wake_o = q.wake;
   assign irq_o = q.irq;

endmodule

// [rtl/lvd_defines.svh]
/*
 * Constants of the low-voltage detector control block: register
 * offsets, field positions, reset values and timing counts.
 * Assumes it is included by bare name from the package and modules.
 */
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

// =====================================================================
// Register map
`define LVD_ADDR_W 2
`define LVD_DATA_W 8
`define LVD_CTRL_ADDR 2'h0
`define LVD_IRQ_ADDR 2'h1
`define LVD_STAT_ADDR 2'h2

// =====================================================================
// Control register fields
`define LVD_CTRL_STABLE_BIT 5
`define LVD_CTRL_EN_BIT 4
`define LVD_CTRL_SEL_MSB 3
`define LVD_CTRL_SEL_LSB 0
`define LVD_SEL_W 4
`define LVD_SEL_RESET 4'h5
`define LVD_SEL_EXTERNAL 4'hF
`define LVD_SEL_MAX 4'hE
`define LVD_SEL_MIN 4'h2

// =====================================================================
// Interrupt control register fields
`define LVD_IRQ_FLAG_BIT 0
`define LVD_IRQ_IE_BIT 1
`define LVD_IRQ_GIE_BIT 2

// =====================================================================
// Status register fields
`define LVD_STAT_STABLE_BIT 0
`define LVD_STAT_REF_ON_BIT 1
`define LVD_STAT_UNSAFE_BIT 2
`define LVD_STAT_RSVD_BIT 3
`define LVD_STAT_EXT_BIT 4
`define LVD_STAT_SLEEP_BIT 5

// =====================================================================
// Timing
`define LVD_CLK_PERIOD_NS 100
`define LVD_REF_STARTUP_NS 20000
`define LVD_REF_STARTUP_CYC \
   ((`LVD_REF_STARTUP_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)

`endif

// [rtl/lvd_pkg.sv]
/*
 * Types of the low-voltage detector control block.
 * Assumes lvd_defines.svh is on the include path.
 */
`include "lvd_defines.svh"

package lvd_pkg;

   // ==================================================================
   // Register state of the control block
   typedef struct packed {
      logic en;
      logic [`LVD_SEL_W-1:0] sel;
      logic flag;
      logic ie;
      logic global_irq_enable;
      logic stable;
      logic [`LVD_DATA_W-1:0] rdata;
      logic irq;
      logic wake;
      logic pwr;
      logic div_en;
      logic ext;
      logic ref_en;
      logic [`LVD_SEL_W-1:0] tap;
   } lvd_state_t;

endpackage

// [rtl/lvd_sync.sv]
/*
 * Two-flip-flop synchroniser for a group of independent levels.
 * Assumes each input bit is a slow level from outside the clock domain.
 */
`timescale 1ns/10ps

module lvd_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } sync_state_t;

   sync_state_t q;
   sync_state_t d;

   always_comb begin
      d = q;
      d.meta = async_i;
      d.sync = q.meta;
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sync_o = q.sync;

endmodule

// [rtl/lvd_ref_timer.sv]
/*
 * Reference start-up timer: counts a fixed number of clock cycles
 * after the shared reference is switched on, then reports done.
 * Assumes ref_on_i comes from logic on the same clock.
 */
`timescale 1ns/10ps

module lvd_ref_timer #(
   parameter int COUNT = 200,
   parameter int CNT_W = 16
) (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic ref_on_i,
   output logic done_o
);

   typedef struct packed {
      logic [CNT_W-1:0] cnt;
      logic done;
   } timer_state_t;

   localparam logic [CNT_W-1:0] LAST = CNT_W'(COUNT - 1);

   timer_state_t q;
   timer_state_t d;

   always_comb begin
      d = q;
      if (!ref_on_i) begin
         d.cnt = '0;
         d.done = 1'b0;
      end else if (q.cnt == LAST) begin
         d.done = 1'b1;
      end else begin
         d.cnt = q.cnt + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (!rstn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign done_o = q.done;

endmodule

// [verif/lvd_checker.sv]
/* Port assertions of the detector control block.
   Assumes it is bound into low_voltage_detector. */
`timescale 1ns/10ps
`include "lvd_defines.svh"
module lvd_checker (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic [`LVD_ADDR_W-1:0] addr_i,
   input wire logic [`LVD_DATA_W-1:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [`LVD_DATA_W-1:0] rdata_o,
   input wire logic sleep_i,
   input wire logic detector_power_enable_o,
   input wire logic divider_enable_o,
   input wire logic [`LVD_SEL_W-1:0] trip_point_select_o,
   input wire logic external_sense_input_o,
   input wire logic reference_enable_o,
   input wire logic wake_o,
   input wire logic irq_o
);
   // =================================================================
   // Assertions
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!rstn_i);
   a_ctrl_top_zero: assert property ($past(rd_i) &&
      $past(addr_i) == `LVD_CTRL_ADDR |-> rdata_o[7:6] == 2'h0)
      else $error("control bits 7..6 not zero");
   a_write_powers_up: assert property (wr_i &&
      addr_i == `LVD_CTRL_ADDR |-> ##2
      detector_power_enable_o == $past(wdata_i[4], 2))
      else $error("power enable does not follow write");
   a_power_off_idle: assert property (!detector_power_enable_o |->
      !divider_enable_o && !external_sense_input_o)
      else $error("sense path active while powered down");
   a_external_mode: assert property (external_sense_input_o |->
      !divider_enable_o && trip_point_select_o == `LVD_SEL_EXTERNAL)
      else $error("external sense with divider or wrong select");
   a_tap_range: assert property (divider_enable_o |->
      trip_point_select_o inside {[`LVD_SEL_MIN:`LVD_SEL_MAX]})
      else $error("divider tap outside legal range");
   a_ref_shared: assert property (detector_power_enable_o |->
      reference_enable_o)
      else $error("reference off while detector powered");
   a_wake_in_sleep: assert property (wake_o |-> $past(sleep_i))
      else $error("wake without sleep");
   a_reset_value: assert property ($rose(rstn_i) |->
      trip_point_select_o == `LVD_SEL_RESET &&
      !detector_power_enable_o && !irq_o)
      else $error("outputs not at reset value");
   c_irq: cover property ($rose(irq_o));
   c_wake: cover property ($rose(wake_o));
   c_ext: cover property ($rose(external_sense_input_o));
endmodule

bind low_voltage_detector lvd_checker lvd_checker_i (
   .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
   .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
   .sleep_i(sleep_i), .detector_power_enable_o(detector_power_enable_o),
   .divider_enable_o(divider_enable_o), .wake_o(wake_o), .irq_o(irq_o),
   .trip_point_select_o(trip_point_select_o),
   .external_sense_input_o(external_sense_input_o),
   .reference_enable_o(reference_enable_o)
);

// [verif/low_voltage_detector_bench.sv]
/* Self-checking bench of the detector control block.
   Assumes design and checker are compiled before it. */
`timescale 1ns/10ps
`include "lvd_defines.svh"
module low_voltage_detector_bench;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
   logic [1:0] addr_i = 2'h0;
   logic [7:0] wdata_i = 8'h00, rdata_o, r;
   logic sleep_i = 1'b0, comparator_low_i = 1'b0, reference_ok_i = 1'b1;
   logic brownout_ref_on_i = 1'b0, rd_pend = 1'b0;
   logic [3:0] trip_point_select_o;
   logic detector_power_enable_o, divider_enable_o, external_sense_input_o;
   logic reference_enable_o, wake_o, irq_o;
   logic [7:0] exp_q[$];
   int miscompares = 0, n_tests = 0, i;
   integer seed = 32'hA3C6;
   always #50 core_clk_i = ~core_clk_i;
   low_voltage_detector #(.REF_STARTUP_CYC(4)) low_voltage_detector_i (
      .core_clk_i(core_clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .sleep_i(sleep_i), .comparator_low_i(comparator_low_i),
      .reference_ok_i(reference_ok_i), .wake_o(wake_o), .irq_o(irq_o),
      .brownout_ref_on_i(brownout_ref_on_i),
      .detector_power_enable_o(detector_power_enable_o),
      .divider_enable_o(divider_enable_o),
      .trip_point_select_o(trip_point_select_o),
      .external_sense_input_o(external_sense_input_o),
      .reference_enable_o(reference_enable_o));
   // =================================================================
   // Tasks
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_rd();
      chk(rdata_o, exp_q.pop_front());
   endtask
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge core_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      exp_q.push_back(e);
      @(posedge core_clk_i);
      rd_i <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge core_clk_i);
      @(negedge core_clk_i);
   endtask
   task automatic wait_hi(input bit w);
      @(negedge core_clk_i);
      for (int k = 0; k < 20 && (w ? wake_o : irq_o) !== 1'b1; k++)
         @(negedge core_clk_i);
   endtask
   task automatic final_report;
      $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Read data stand in the cycle after the strobe
   always @(posedge core_clk_i) rd_pend <= rd_i & rstn_i;
   always @(negedge core_clk_i) if (rd_pend) chk_rd();
   initial begin
      #300000;
      miscompares++;
      final_report;
   end
   // =================================================================
   // Scenarios
   initial begin
      repeat (16) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      rd(`LVD_CTRL_ADDR, 8'h05);
      rd(`LVD_IRQ_ADDR, 8'h00);
      rd(2'h3, 8'h00);
      reference_ok_i <= 1'b0;
      wr(`LVD_CTRL_ADDR, 8'hF5);
      comparator_low_i <= 1'b1;
      settle(20);
      chk(detector_power_enable_o, 8'h01);
      rd(`LVD_CTRL_ADDR, 8'h15);
      rd(`LVD_IRQ_ADDR, 8'h00);
      wr(`LVD_IRQ_ADDR, 8'h02);
      rd(`LVD_STAT_ADDR, 8'h06);
      comparator_low_i <= 1'b0;
      reference_ok_i <= 1'b1;
      settle(8);
      rd(`LVD_CTRL_ADDR, 8'h35);
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         wr(`LVD_CTRL_ADDR, {r[7:5], 1'b1, i[3:0]});
         settle(2);
         chk(trip_point_select_o, (i < 2) ? 8'h02 : i[7:0]);
         chk(external_sense_input_o, 8'(i == 15));
         chk(divider_enable_o, 8'(i != 15));
         rd(`LVD_CTRL_ADDR, {4'h3, i[3:0]});
         rd(`LVD_STAT_ADDR, {3'h0, i == 15, i < 2, 3'h3});
      end
      wr(`LVD_CTRL_ADDR, 8'h15);
      wr(`LVD_IRQ_ADDR, 8'h00);
      wr(`LVD_IRQ_ADDR, 8'h06);
      comparator_low_i <= 1'b1;
      wait_hi(1'b0);
      chk(irq_o, 8'h01);
      @(posedge core_clk_i);
      comparator_low_i <= 1'b0;
      settle(5);
      rd(`LVD_IRQ_ADDR, 8'h07);
      wr(`LVD_IRQ_ADDR, 8'h06);
      settle(2);
      chk(irq_o, 8'h00);
      @(posedge core_clk_i);
      sleep_i <= 1'b1;
      wr(`LVD_IRQ_ADDR, 8'h02);
      comparator_low_i <= 1'b1;
      wait_hi(1'b1);
      chk(wake_o, 8'h01);
      chk(irq_o, 8'h00);
      wr(`LVD_IRQ_ADDR, 8'h07);
      settle(1);
      chk(irq_o, 8'h01);
      @(posedge core_clk_i);
      sleep_i <= 1'b0;
      comparator_low_i <= 1'b0;
      settle(4);
      wr(`LVD_IRQ_ADDR, 8'h00);
      wr(`LVD_CTRL_ADDR, 8'h05);
      brownout_ref_on_i <= 1'b1;
      settle(5);
      chk(detector_power_enable_o, 8'h00);
      chk(reference_enable_o, 8'h01);
      wr(`LVD_CTRL_ADDR, 8'h1F);
      rstn_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      rd(`LVD_CTRL_ADDR, 8'h05);
      settle(1);
      chk(detector_power_enable_o, 8'h00);
      final_report;
   end
endmodule
